// file: logic/flash_port_cfg.svh
// Purpose: Constants for the flash program/erase bus port
// Assumes: 100 MHz system clock
// Notes: Times are kept in their own unit, window and toggle cycle counts derive from them; program and erase counts are given in cycles
`ifndef FLASH_PORT_CFG_SVH
`define FLASH_PORT_CFG_SVH
`define FP_CLK_PERIOD_NS 10
`define FP_SEA_TOUT_US 50
`define FP_SEA_CYC (`FP_SEA_TOUT_US * 1000 / `FP_CLK_PERIOD_NS)
`define FP_PROT_TOG_US 0
`define FP_PROT_TOG_RAW (`FP_PROT_TOG_US * 1000 / `FP_CLK_PERIOD_NS)
`define FP_PROT_TOG_CYC ((`FP_PROT_TOG_RAW < 1) ? 1 : `FP_PROT_TOG_RAW)
`define FP_PROG_CYC 64
`define FP_ERASE_CYC 256
`define FP_ADDR_W 24
`define FP_UNLOCK_BITS 14
`define FP_UNLOCK_ADDR1 14'h0555
`define FP_UNLOCK_ADDR2 14'h02AA
`define FP_CMD_UNLOCK1 8'hAA
`define FP_CMD_UNLOCK2 8'h55
`define FP_CMD_PROGRAM 8'hA0
`define FP_CMD_ERASE 8'h80
`define FP_CMD_SECTOR 8'h30
`define FP_WS_MIN 3'h2
`define FP_WS_MAX 3'h7
`define FP_ERASED 16'hFFFF
`define FP_STATUS_POLL 7
`define FP_STATUS_TOGGLE 6
`endif

// file: logic/flash_port_pkg.sv
// Purpose: Types shared by the flash bus port
// Assumes: Constants live in flash_port_cfg.svh
// Notes: Address field widths follow the 24-bit bus
`default_nettype none
package flash_port_pkg;
    typedef enum logic [3:0] {
        ST_READ, ST_UNL1, ST_UNL2, ST_PGM, ST_ERA3, ST_ERA4, ST_ERA5,
        ST_SEA, ST_PROG, ST_ERASE, ST_PROT
    } cmd_state_t;

    typedef struct packed {
        logic bus_clk;
        logic write_n;
        logic output_en_n;
        logic chip_sel_n;
        logic address_valid_n;
    } bus_ctl_t;

    typedef struct packed {
        cmd_state_t state;
        logic [15:0] tmr;
        logic [23:0] wf_addr;
        logic sync_lat;
        logic [23:0] lat_addr;
        logic [23:0] op_addr;
        logic [15:0] op_data;
        logic [3:0] er_sel;
        logic tog;
        logic rd_act;
        logic [23:0] rd_addr;
        logic [2:0] rd_cnt;
        logic [15:0] dq;
        logic dq_oe;
        logic rdy;
        logic busy;
    } port_st_t;
endpackage : flash_port_pkg
`default_nettype wire

// file: logic/pin_edge.sv
// Purpose: Edge pulses for bus pins sampled on the system clock
// Assumes: Pins are synchronous to mclk_i
// Notes: One generate slice per pin
`timescale 1ns/1ps
`default_nettype none
module pin_edge #(
    parameter int W = 5
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Pins
    input wire logic [W-1:0] pins_i,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] prev_r;

    for (genvar i = 0; i < W; i++) begin : g_pin
        always_ff @(posedge mclk_i) begin
            if (sys_rst_i) begin
                prev_r[i] <= 1'b1;
            end else begin
                prev_r[i] <= pins_i[i];
            end
        end
        assign rise_o[i] = pins_i[i] & ~prev_r[i];
        assign fall_o[i] = ~pins_i[i] & prev_r[i];
    end
endmodule : pin_edge
`default_nettype wire

// file: logic/flash_port.sv
// Purpose: Flash bus port for program, erase and status polling
// Assumes: All bus pins synchronous to mclk_i; bus clock sampled as a pin
// Notes: Small array model; sectors are the top two array address bits
`timescale 1ns/1ps
`default_nettype none
`include "flash_port_cfg.svh"
module flash_port #(
    parameter int AW = 10,
    parameter int SEA_CYC = `FP_SEA_CYC,
    parameter int PROG_CYC = `FP_PROG_CYC,
    parameter int ERASE_CYC = `FP_ERASE_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Flash bus pins
    input wire logic hw_rst_n_i,
    input wire logic bus_clk_i,
    input wire logic chip_sel_n_i,
    input wire logic address_valid_n_i,
    input wire logic write_n_i,
    input wire logic output_en_n_i,
    input wire logic [23:0] addr_i,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic dq_oe_o,
    output logic ready_o,
    // Configuration
    input wire logic sync_read_mode_i,
    input wire logic ready_early_select_i,
    input wire logic [2:0] wait_states_i,
    input wire logic [3:0] sector_protect_i,
    // Status
    output logic busy_o
);
    localparam int NW = 1 << AW;
    localparam int PROT_CYC = `FP_PROT_TOG_CYC;

    flash_port_pkg::port_st_t st_r;
    flash_port_pkg::port_st_t st_nxt;
    flash_port_pkg::bus_ctl_t ctl;
    flash_port_pkg::bus_ctl_t rise;
    flash_port_pkg::bus_ctl_t fall;
    logic [15:0] mem_r [0:NW-1];
    logic prog_done;
    logic erase_done;
    logic [2:0] ws;
    logic [3:0] er_eff;
    logic [15:0] word_now;

    assign ctl = '{bus_clk: bus_clk_i, write_n: write_n_i, output_en_n: output_en_n_i,
                   chip_sel_n: chip_sel_n_i, address_valid_n: address_valid_n_i};

    pin_edge #(.W(5)) u_edge (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .pins_i(ctl),
        .rise_o(rise),
        .fall_o(fall)
    );

    // Out-of-range settings clamp rather than stall the burst
    assign ws = (wait_states_i < `FP_WS_MIN) ? `FP_WS_MIN : wait_states_i;
    assign er_eff = st_r.er_sel & ~sector_protect_i;

    function automatic logic [15:0] word_at(input logic [23:0] a);
        logic [15:0] w;
        w = mem_r[a[AW-1:0]];
        if (st_r.busy) begin
            w = 16'h0000;
            w[`FP_STATUS_POLL] = (st_r.state == flash_port_pkg::ST_PROG) ?
                                 ~st_r.op_data[`FP_STATUS_POLL] : 1'b0;
            w[`FP_STATUS_TOGGLE] = st_r.tog;
        end
        return w;
    endfunction : word_at

    always_comb begin
        logic commit;
        logic [23:0] wa;
        logic [13:0] lo;
        logic [7:0] wd;
        logic [3:0] sec1h;
        logic rd_on;
        commit = 1'b0;
        wa = 24'h00_0000;
        lo = 14'h0000;
        wd = 8'h00;
        sec1h = 4'h0;
        rd_on = 1'b0;
        st_nxt = st_r;
        prog_done = 1'b0;
        erase_done = 1'b0;
        rd_on = !ctl.chip_sel_n && !ctl.output_en_n && ctl.write_n;
        // Clock form only exists in sync read mode
        if (rise.bus_clk && !ctl.chip_sel_n && !ctl.address_valid_n
            && sync_read_mode_i) begin
            st_nxt.sync_lat = 1'b1;
            st_nxt.lat_addr = addr_i;
            st_nxt.rd_act = ctl.write_n;
            st_nxt.rd_addr = addr_i;
            st_nxt.rd_cnt = 3'h0;
            if (st_r.busy) begin
                st_nxt.tog = ~st_r.tog;
            end
        end else if (rise.bus_clk && st_r.rd_act) begin
            if (st_r.rd_cnt < `FP_WS_MAX) begin
                st_nxt.rd_cnt = st_r.rd_cnt + 3'h1;
            end
            if (st_r.rd_cnt >= ws) begin
                st_nxt.rd_addr = st_r.rd_addr + 24'h00_0001;
            end
        end
        if (fall.output_en_n && !ctl.chip_sel_n && !st_r.rd_act && st_r.busy) begin
            st_nxt.tog = ~st_r.tog;
        end
        if (fall.write_n && !ctl.chip_sel_n) begin
            st_nxt.wf_addr = addr_i;
            st_nxt.rd_act = 1'b0;
        end
        if (rise.chip_sel_n) begin
            st_nxt.sync_lat = 1'b0;
            st_nxt.rd_act = 1'b0;
        end
        commit = rise.write_n && !ctl.chip_sel_n;
        // Write-fall address serves async form in either read mode
        wa = st_r.sync_lat ? st_r.lat_addr : st_r.wf_addr;
        lo = wa[`FP_UNLOCK_BITS-1:0];
        wd = dq_i[7:0];
        sec1h = 4'h1 << wa[AW-1:AW-2];
        if (commit) begin
            st_nxt.sync_lat = 1'b0;
        end
        case (st_r.state)
            flash_port_pkg::ST_READ: begin
                if (commit && lo == `FP_UNLOCK_ADDR1 && wd == `FP_CMD_UNLOCK1) begin
                    st_nxt.state = flash_port_pkg::ST_UNL1;
                end
            end
            flash_port_pkg::ST_UNL1, flash_port_pkg::ST_ERA4: begin
                if (commit) begin
                    if (lo == `FP_UNLOCK_ADDR2 && wd == `FP_CMD_UNLOCK2) begin
                        st_nxt.state = (st_r.state == flash_port_pkg::ST_UNL1) ?
                            flash_port_pkg::ST_UNL2 : flash_port_pkg::ST_ERA5;
                    end else begin
                        st_nxt.state = flash_port_pkg::ST_READ;
                    end
                end
            end
            flash_port_pkg::ST_UNL2: begin
                if (commit) begin
                    st_nxt.state = flash_port_pkg::ST_READ;
                    if (lo == `FP_UNLOCK_ADDR1 && wd == `FP_CMD_PROGRAM) begin
                        st_nxt.state = flash_port_pkg::ST_PGM;
                    end else if (lo == `FP_UNLOCK_ADDR1 && wd == `FP_CMD_ERASE) begin
                        st_nxt.state = flash_port_pkg::ST_ERA3;
                    end
                end
            end
            flash_port_pkg::ST_PGM: begin
                if (commit) begin
                    st_nxt.op_addr = wa;
                    st_nxt.op_data = dq_i;
                    st_nxt.tmr = 16'h0000;
                    st_nxt.state = sector_protect_i[wa[AW-1:AW-2]] ?
                        flash_port_pkg::ST_PROT : flash_port_pkg::ST_PROG;
                end
            end
            flash_port_pkg::ST_ERA3: begin
                if (commit) begin
                    st_nxt.state = (lo == `FP_UNLOCK_ADDR1 && wd == `FP_CMD_UNLOCK1) ?
                        flash_port_pkg::ST_ERA4 : flash_port_pkg::ST_READ;
                end
            end
            flash_port_pkg::ST_ERA5: begin
                if (commit) begin
                    st_nxt.state = flash_port_pkg::ST_READ;
                    if (wd == `FP_CMD_SECTOR) begin
                        st_nxt.state = flash_port_pkg::ST_SEA;
                        st_nxt.er_sel = sec1h;
                        st_nxt.tmr = 16'h0000;
                    end
                end
            end
            flash_port_pkg::ST_SEA: begin
                // Timer is not restarted, so the window never stretches
                st_nxt.tmr = st_r.tmr + 16'h0001;
                if (commit && wd == `FP_CMD_SECTOR) begin
                    st_nxt.er_sel = st_r.er_sel | sec1h;
                end
                if (st_r.tmr == 16'(SEA_CYC - 1)) begin
                    st_nxt.tmr = 16'h0000;
                    st_nxt.state = (er_eff == 4'h0) ? flash_port_pkg::ST_PROT
                                                    : flash_port_pkg::ST_ERASE;
                end
            end
            flash_port_pkg::ST_PROG: begin
                st_nxt.tmr = st_r.tmr + 16'h0001;
                if (st_r.tmr == 16'(PROG_CYC - 1)) begin
                    prog_done = 1'b1;
                    st_nxt.state = flash_port_pkg::ST_READ;
                end
            end
            flash_port_pkg::ST_ERASE: begin
                st_nxt.tmr = st_r.tmr + 16'h0001;
                if (st_r.tmr == 16'(ERASE_CYC - 1)) begin
                    erase_done = 1'b1;
                    st_nxt.state = flash_port_pkg::ST_READ;
                end
            end
            flash_port_pkg::ST_PROT: begin
                st_nxt.tmr = st_r.tmr + 16'h0001;
                if (st_r.tmr == 16'(PROT_CYC - 1)) begin
                    st_nxt.state = flash_port_pkg::ST_READ;
                end
            end
            default: begin
                st_nxt.state = flash_port_pkg::ST_READ;
            end
        endcase
        if (!hw_rst_n_i) begin
            st_nxt.state = flash_port_pkg::ST_READ;
            st_nxt.tmr = 16'h0000;
            st_nxt.sync_lat = 1'b0;
            st_nxt.rd_act = 1'b0;
            prog_done = 1'b0;
            erase_done = 1'b0;
        end
        st_nxt.busy = st_nxt.state inside {flash_port_pkg::ST_SEA, flash_port_pkg::ST_PROG,
                                           flash_port_pkg::ST_ERASE, flash_port_pkg::ST_PROT};
        // Drive outputs from next-state so they align with the counter
        st_nxt.dq = word_at(st_nxt.rd_act ? st_nxt.rd_addr : addr_i);
        st_nxt.dq_oe = rd_on && hw_rst_n_i && (!st_nxt.rd_act || st_nxt.rd_cnt >= ws);
        if (!st_nxt.rd_act) begin
            st_nxt.rdy = 1'b1;
        end else if (ready_early_select_i) begin
            st_nxt.rdy = st_nxt.rd_cnt >= ws;
        end else begin
            st_nxt.rdy = {1'b0, st_nxt.rd_cnt} + 4'h1 >= {1'b0, ws};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Flash only clears bits on program; erase sets the whole sector
    for (genvar i = 0; i < NW; i++) begin : g_word
        always_ff @(posedge mclk_i) begin
            if (erase_done && er_eff[i >> (AW - 2)]) begin
                mem_r[i] <= `FP_ERASED;
            end else if (prog_done && st_r.op_addr[AW-1:0] == AW'(i)) begin
                mem_r[i] <= mem_r[i] & st_r.op_data;
            end
        end
    end

    assign dq_o = st_r.dq;
    assign dq_oe_o = st_r.dq_oe;
    assign ready_o = st_r.rdy;
    assign busy_o = st_r.busy;
    assign word_now = mem_r[addr_i[AW-1:0]];

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i || !hw_rst_n_i);

    sequence s_unlock1;
        rise.write_n && !ctl.chip_sel_n && !st_r.sync_lat
        && st_r.state == flash_port_pkg::ST_READ
        && st_r.wf_addr[13:0] == `FP_UNLOCK_ADDR1 && dq_i[7:0] == `FP_CMD_UNLOCK1;
    endsequence
    sequence s_sea_last;
        st_r.state == flash_port_pkg::ST_SEA && st_r.tmr == 16'(SEA_CYC - 1);
    endsequence

    AST_SYNC_ONLY_IN_SYNC: assert property ($rose(st_r.sync_lat) |-> $past(sync_read_mode_i))
        else $error("clock address latched in async read mode");
    AST_CLK_LATCH: assert property (rise.bus_clk && !ctl.chip_sel_n && !ctl.address_valid_n
        && sync_read_mode_i |=> st_r.sync_lat && st_r.lat_addr == $past(addr_i))
        else $error("clock edge did not latch address");
    AST_WE_FALL_LATCH: assert property (fall.write_n && !ctl.chip_sel_n
        |=> st_r.wf_addr == $past(addr_i))
        else $error("write fall did not latch address");
    AST_ASYNC_UNLOCK: assert property (s_unlock1 |=> st_r.state == flash_port_pkg::ST_UNL1)
        else $error("async unlock cycle not accepted");
    AST_SEA_CLOSE: assert property (s_sea_last |=> st_r.state != flash_port_pkg::ST_SEA)
        else $error("erase window exceeded");
    AST_SEA_BOUND: assert property (st_r.state == flash_port_pkg::ST_SEA |-> st_r.tmr < 16'(SEA_CYC))
        else $error("erase window timer overran");
    AST_PROT_BRIEF: assert property ($rose(st_r.state == flash_port_pkg::ST_PROT)
        |-> ##1 st_r.state == flash_port_pkg::ST_READ)
        else $error("protected toggle too long");
    AST_TRUE_DATA: assert property (!st_r.busy && !st_nxt.busy && !st_r.rd_act
        // Unwritten words stay unknown until erased
        && !st_nxt.rd_act && !prog_done && !erase_done |=> st_r.dq === $past(word_now))
        else $error("idle read not true data");
    AST_READY_TIMING: assert property (st_r.rd_act && st_r.rd_cnt < ws && $stable(ws)
        && $stable(ready_early_select_i) |-> st_r.rdy == (!ready_early_select_i
        && {1'b0, st_r.rd_cnt} + 4'h1 == {1'b0, ws}))
        else $error("ready timing wrong");
    AST_WS_RANGE: assert property (ws >= `FP_WS_MIN && ws <= `FP_WS_MAX)
        else $error("wait states out of range");
endmodule : flash_port
`default_nettype wire

// file: verification/flash_host_model.sv
// Purpose: Host memory controller model driving the flash bus pins
// Assumes: Pins change only at falling mclk edges
// Notes: Released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
`include "flash_port_cfg.svh"
module flash_host_model (
    // Clock
    input wire logic mclk_i,
    // Read back from the device
    input wire logic [15:0] rd_data_i,
    input wire logic ready_i,
    input wire logic data_oe_i,
    // Bus pins
    output logic hw_rst_n_o,
    output logic bus_clk_o,
    output logic chip_sel_n_o,
    output logic address_valid_n_o,
    output logic write_n_o,
    output logic output_en_n_o,
    output logic [23:0] addr_o,
    output logic [15:0] dq_o
);
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : tick

    // Stale values would let a late latch look correct
    task automatic release_bus();
        chip_sel_n_o = 1'b1;
        address_valid_n_o = 1'b1;
        write_n_o = 1'b1;
        output_en_n_o = 1'b1;
        addr_o = ~addr_o;
        dq_o = ~dq_o;
    endtask : release_bus

    task automatic pulse();
        bus_clk_o = 1'b1;
        tick(1);
        bus_clk_o = 1'b0;
        tick(1);
    endtask : pulse

    task automatic wr(input logic [23:0] fa, input logic [23:0] ca, input logic [15:0] d,
                      input logic cf);
        tick(1);
        chip_sel_n_o = 1'b0;
        if (cf) begin
            address_valid_n_o = 1'b0;
            addr_o = ca;
            pulse();
            address_valid_n_o = 1'b1;
        end
        addr_o = fa;
        dq_o = d;
        tick(1);
        write_n_o = 1'b0;
        tick(2);
        addr_o = ~fa;
        tick(1);
        write_n_o = 1'b1;
        tick(1);
        release_bus();
    endtask : wr

    // Wrong address goes on whichever path must be ignored
    task automatic cmd(input logic [13:0] a, input logic [15:0] d, input logic f,
                       input logic sm);
        logic [23:0] r;
        r = {10'h2d3, a};
        if (!f) wr(r, r, d, 1'b0);
        else if (sm) wr(~r, r, d, 1'b1);
        else wr(r, ~r, d, 1'b1);
    endtask : cmd

    task automatic unlock(input logic f, input logic sm);
        cmd(`FP_UNLOCK_ADDR1, {8'h00, `FP_CMD_UNLOCK1}, f, sm);
        cmd(`FP_UNLOCK_ADDR2, {8'h00, `FP_CMD_UNLOCK2}, f, sm);
    endtask : unlock

    task automatic prog_word(input logic [13:0] tgt_addr, input logic [15:0] tgt_word,
                             input logic f, input logic sm);
        unlock(f, sm);
        cmd(`FP_UNLOCK_ADDR1, {8'h00, `FP_CMD_PROGRAM}, f, sm);
        cmd(tgt_addr, tgt_word, f, sm);
    endtask : prog_word

    task automatic erase(input logic [13:0] s0, input logic [13:0] s1);
        unlock(1'b0, 1'b0);
        cmd(`FP_UNLOCK_ADDR1, {8'h00, `FP_CMD_ERASE}, 1'b0, 1'b0);
        unlock(1'b0, 1'b0);
        cmd(s0, {8'h00, `FP_CMD_SECTOR}, 1'b0, 1'b0);
        cmd(s1, {8'h00, `FP_CMD_SECTOR}, 1'b0, 1'b0);
    endtask : erase

    task automatic rd(input logic [23:0] a, output logic [15:0] v);
        tick(1);
        chip_sel_n_o = 1'b0;
        output_en_n_o = 1'b0;
        addr_o = a;
        tick(2);
        v = rd_data_i;
        release_bus();
    endtask : rd

    // Bus clock count of first ready and first valid data after the latch
    task automatic sync_rd(input logic [23:0] a, output int rk, output int dk);
        rk = 0;
        dk = 0;
        tick(1);
        chip_sel_n_o = 1'b0;
        address_valid_n_o = 1'b0;
        output_en_n_o = 1'b0;
        addr_o = a;
        pulse();
        address_valid_n_o = 1'b1;
        for (int k = 1; k <= 9; k++) begin
            pulse();
            tick(1);
            if (rk == 0 && ready_i === 1'b1) rk = k;
            if (dk == 0 && data_oe_i === 1'b1) dk = k;
        end
        release_bus();
    endtask : sync_rd

    task automatic hw_reset();
        hw_rst_n_o = 1'b0;
        tick(3);
        hw_rst_n_o = 1'b1;
        tick(20);
    endtask : hw_reset

    initial begin
        hw_rst_n_o = 1'b1;
        bus_clk_o = 1'b0;
        addr_o = '0;
        dq_o = '0;
        release_bus();
    end
endmodule : flash_host_model
`default_nettype wire

// file: verification/flash_port_test.sv
// Purpose: Self-checking bench for the flash program/erase bus port
// Assumes: Short counts via parameters; host model drives the bus
// Notes: Sector contents checked after an erase and after each program into an unprotected sector
`timescale 1ns/1ps
`default_nettype none
`include "flash_port_cfg.svh"
module flash_port_test;
    localparam int SEA_CYC = 20;
    localparam int PROG_CYC = 4;
    localparam int ERASE_CYC = 8;
    logic mclk_i, sys_rst_i, sync_mode, early_sel, dq_oe, ready, busy;
    logic hw_rst_n, bus_clk, chip_sel_n, address_valid_n, write_n, output_en_n;
    logic [23:0] addr;
    logic [15:0] dq_in, dq_out;
    logic [2:0] wait_states;
    logic [3:0] sector_protect;
    int mismatches, checks_done, busy_cnt;

    flash_port #(.AW(4), .SEA_CYC(SEA_CYC), .PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) dut_u (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hw_rst_n_i(hw_rst_n), .bus_clk_i(bus_clk),
        .chip_sel_n_i(chip_sel_n), .address_valid_n_i(address_valid_n), .write_n_i(write_n),
        .output_en_n_i(output_en_n), .addr_i(addr), .dq_i(dq_in), .dq_o(dq_out),
        .dq_oe_o(dq_oe), .ready_o(ready), .sync_read_mode_i(sync_mode),
        .ready_early_select_i(early_sel), .wait_states_i(wait_states),
        .sector_protect_i(sector_protect), .busy_o(busy));

    flash_host_model host_u (
        .mclk_i(mclk_i), .rd_data_i(dq_out), .ready_i(ready), .data_oe_i(dq_oe),
        .hw_rst_n_o(hw_rst_n), .bus_clk_o(bus_clk), .chip_sel_n_o(chip_sel_n),
        .address_valid_n_o(address_valid_n), .write_n_o(write_n),
        .output_en_n_o(output_en_n), .addr_o(addr), .dq_o(dq_in));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) if (busy === 1'b1) busy_cnt <= busy_cnt + 1;

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk_rng(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_rng

    task automatic wait_idle();
        int n;
        n = 0;
        host_u.tick(3);
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge mclk_i);
            n++;
        end
        if (n == 2000) begin
            mismatches++;
            $display("Error at %0t: busy never cleared", $time);
            close_out();
        end
    endtask : wait_idle

    task automatic t_erase();
        logic [15:0] v1, v2;
        busy_cnt = 0;
        host_u.erase(14'h0000, 14'h0004);
        host_u.rd(24'h00_0000, v1);
        host_u.rd(24'h00_0000, v2);
        chk16({15'h0000, v1[7]}, 16'h0000);
        chk16({15'h0000, v1[6] ^ v2[6]}, 16'h0001);
        wait_idle();
        chk_rng(busy_cnt, ERASE_CYC, SEA_CYC + ERASE_CYC + 3);
        host_u.rd(24'h00_0000, v1);
        chk16(v1, 16'hffff);
        host_u.rd(24'h00_0004, v1);
        chk16(v1, 16'hffff);
        $display("test erase done");
    endtask : t_erase

    // Both read modes against both write forms
    task automatic t_program();
        logic [15:0] v;
        for (int k = 0; k < 4; k++) begin
            sync_mode = k[1];
            host_u.tick(1);
            host_u.prog_word(14'(k + 1), 16'h5a3c ^ 16'(k), k[0], k[1]);
            wait_idle();
            host_u.rd(24'(k + 1), v);
            chk16(v, 16'h5a3c ^ 16'(k));
        end
        $display("test program done");
    endtask : t_program

    task automatic t_protect();
        sector_protect = 4'h8;
        busy_cnt = 0;
        host_u.erase(14'h000c, 14'h000c);
        wait_idle();
        chk_rng(busy_cnt, 1, SEA_CYC + 3);
        // Program into a protected sector only toggles briefly
        busy_cnt = 0;
        host_u.prog_word(14'h000d, 16'h0000, 1'b0, 1'b0);
        wait_idle();
        chk_rng(busy_cnt, 1, 3);
        sector_protect = 4'h0;
        $display("test protect done");
    endtask : t_protect

    task automatic t_hwrst();
        host_u.erase(14'h0008, 14'h0008);
        host_u.hw_reset();
        chk16({15'h0000, busy}, 16'h0000);
        $display("test hwreset done");
    endtask : t_hwrst

    task automatic t_sync_read();
        int rk, dk, ws;
        sync_mode = 1'b1;
        for (int k = 0; k < 4; k++) begin
            early_sel = k[0];
            wait_states = k[1] ? `FP_WS_MAX : `FP_WS_MIN;
            ws = int'(wait_states);
            host_u.sync_rd(24'h00_0001, rk, dk);
            chk_rng(dk, ws, ws);
            chk_rng(rk, ws - 1 + k[0], ws - 1 + k[0]);
        end
        $display("test sync read done");
    endtask : t_sync_read

    initial begin
        sys_rst_i = 1'b1;
        sync_mode = 1'b0;
        early_sel = 1'b1;
        wait_states = 3'h2;
        sector_protect = 4'h0;
        mismatches = 0;
        checks_done = 0;
        busy_cnt = 0;
        repeat (8) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        t_erase();
        t_program();
        t_protect();
        t_hwrst();
        t_sync_read();
        close_out();
    end
endmodule : flash_port_test
`default_nettype wire
